// ### core/spibuf_top.v
// Status flags, data buffer and register slave of the serial unit
`timescale 1ns/1ps
`default_nettype none
`include "spibuf_defines.vh"

module spibuf_top (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Serial clock pin
  input  wire        sck_i,
  output wire        sck_o,
  output reg         sck_oe_n,
  // Master out pin
  input  wire        mosi_i,
  output wire        mosi_o,
  output reg         mosi_oe_n,
  // Master in pin
  input  wire        miso_i,
  output wire        miso_o,
  output reg         miso_oe_n,
  // Slave select input
  input  wire        ss_n_i,
  // Interrupt request
  output reg         irq
);

  // ********************************************************************
  // State
  // ********************************************************************
  reg [3:0]  sync1_r;
  reg [3:0]  sync2_r;
  reg        aw_got_r;
  reg        w_got_r;
  reg [7:0]  awaddr_r;
  reg [31:0] wdata_r;
  reg        wstrb0_r;
  reg        rc_r;
  reg        mf_r;
  reg        tx_full_r;
  reg        seen_rc_r;
  reg        seen_te_r;
  reg        seen_mf_r;
  reg [15:0] data_r;
  reg [15:0] held_r;
  reg        held_v_r;
  reg [15:0] tx_r;
  reg        master_r;
  reg        irq_en_r;
  reg        fde_r;
  reg        wide_r;
  reg [31:0] rd_nxt;
  reg        rd_ok;

  wire       ss_n_s = sync2_r[3];
  wire       sck_s  = sync2_r[2];
  wire       mosi_s = sync2_r[1];
  wire       miso_s = sync2_r[0];
  wire       te     = ~tx_full_r;

  wire       eng_taken;
  wire       eng_start;
  wire       eng_done;
  wire [15:0] eng_rx;
  wire       eng_sck;
  wire       eng_dout;

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  // Only the second stage feeds logic, to keep metastability out
  // Reset to idle pin levels so no false clock edge follows reset
  always @(posedge clk) begin
    if (srst) begin
      sync1_r <= 4'h8;
      sync2_r <= 4'h8;
    end else begin
      sync1_r <= {ss_n_i, sck_i, mosi_i, miso_i};
      sync2_r <= sync1_r;
    end
  end

  // ********************************************************************
  // Bus handshakes and decode
  // ********************************************************************
  wire       aw_hs  = s_axi_awvalid & s_axi_awready;
  wire       w_hs   = s_axi_wvalid & s_axi_wready;
  wire       ar_hs  = s_axi_arvalid & s_axi_arready;
  wire       b_hs   = s_axi_bvalid & s_axi_bready;
  wire       r_hs   = s_axi_rvalid & s_axi_rready;
  wire       wr_go  = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire [3:0] wr_idx = awaddr_r[5:2];
  wire [3:0] rd_idx = s_axi_araddr[5:2];
  wire       wr_hit = (awaddr_r[7:6] == 2'b00) && (awaddr_r[1:0] == 2'b00);
  wire       rd_hit = (s_axi_araddr[7:6] == 2'b00) &&
                      (s_axi_araddr[1:0] == 2'b00);
  wire       wr_en  = wr_go & wr_hit & wstrb0_r;

  // Access events that drive the flag sequences
  wire st_rd  = ar_hs & rd_hit & (rd_idx == `SPIBUF_IDX_STATUS);
  wire lo_rd  = ar_hs & rd_hit & (rd_idx == `SPIBUF_IDX_DLO);
  wire c1_wr  = wr_en & (wr_idx == `SPIBUF_IDX_CTRL1);
  wire c2_wr  = wr_en & (wr_idx == `SPIBUF_IDX_CTRL2);
  wire hi_wr  = wr_en & (wr_idx == `SPIBUF_IDX_DHI) & te;
  wire lo_wr  = wr_en & (wr_idx == `SPIBUF_IDX_DLO) & te;
  wire rc_clr = lo_rd & seen_rc_r & rc_r;
  wire te_clr = lo_wr & seen_te_r;
  wire mf_clr = c1_wr & seen_mf_r & mf_r;
  wire fault  = master_r & fde_r & ~ss_n_s;

  // ********************************************************************
  // Write channel
  // ********************************************************************
  // Address and data are taken in either order, then answered together
  always @(posedge clk) begin
    if (srst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SPIBUF_RESP_OKAY;
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb0_r      <= 1'b0;
    end else begin
      if (aw_hs) begin
        aw_got_r      <= 1'b1;
        awaddr_r      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_r      <= 1'b1;
        wdata_r      <= s_axi_wdata;
        wstrb0_r     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `SPIBUF_RESP_OKAY : `SPIBUF_RESP_SLVERR;
      end
      if (b_hs) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ********************************************************************
  // Read data mux
  // ********************************************************************
  // Status has no writable bits, so its index never reaches a store
  always @* begin
    rd_nxt = 32'h00000000;
    rd_ok  = rd_hit;
    case (rd_idx)
      `SPIBUF_IDX_CTRL1: begin
        rd_nxt[`SPIBUF_IRQEN_BIT] = irq_en_r;
        rd_nxt[`SPIBUF_MASTER_SELECT_BIT]  = master_r;
      end
      `SPIBUF_IDX_CTRL2: begin
        rd_nxt[`SPIBUF_FDE_BIT]   = fde_r;
        rd_nxt[`SPIBUF_WIDTH_BIT] = wide_r;
      end
      `SPIBUF_IDX_STATUS: begin
        rd_nxt[`SPIBUF_RC_BIT] = rc_r;
        rd_nxt[`SPIBUF_TE_BIT] = te;
        rd_nxt[`SPIBUF_MF_BIT] = mf_r;
      end
      `SPIBUF_IDX_DHI: rd_nxt[7:0] = data_r[15:8];
      `SPIBUF_IDX_DLO: rd_nxt[7:0] = data_r[7:0];
      default: rd_ok = 1'b0;
    endcase
  end

  // ********************************************************************
  // Read channel
  // ********************************************************************
  always @(posedge clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SPIBUF_RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_nxt;
      s_axi_rresp   <= rd_ok ? `SPIBUF_RESP_OKAY : `SPIBUF_RESP_SLVERR;
    end else if (r_hs) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ********************************************************************
  // Control registers and mode fault
  // ********************************************************************
  // A fault in the same cycle as a control write beats the master select bit it writes
  always @(posedge clk) begin
    if (srst) begin
      master_r  <= 1'b0;
      irq_en_r  <= 1'b0;
      fde_r     <= 1'b0;
      wide_r    <= 1'b0;
      mf_r      <= 1'b0;
      seen_mf_r <= 1'b0;
    end else begin
      if (c1_wr) begin
        master_r <= wdata_r[`SPIBUF_MASTER_SELECT_BIT];
        irq_en_r <= wdata_r[`SPIBUF_IRQEN_BIT];
      end
      if (c2_wr) begin
        fde_r  <= wdata_r[`SPIBUF_FDE_BIT];
        wide_r <= wdata_r[`SPIBUF_WIDTH_BIT];
      end
      if (st_rd)
        seen_mf_r <= mf_r;
      if (mf_clr) begin
        mf_r      <= 1'b0;
        seen_mf_r <= 1'b0;
      end
      if (fault) begin
        mf_r     <= 1'b1;
        master_r <= 1'b0;
      end
    end
  end

  // ********************************************************************
  // Transmit holding register
  // ********************************************************************
  // Only a low byte write after a status read queues the word
  always @(posedge clk) begin
    if (srst) begin
      tx_r      <= `SPIBUF_DATA_RST;
      tx_full_r <= 1'b0;
      seen_te_r <= 1'b0;
    end else begin
      if (st_rd)
        seen_te_r <= te;
      if (hi_wr)
        tx_r[15:8] <= wdata_r[7:0];
      if (lo_wr)
        tx_r[7:0] <= wdata_r[7:0];
      if (te_clr) begin
        tx_full_r <= 1'b1;
        seen_te_r <= 1'b0;
      end
      if (eng_taken)
        tx_full_r <= 1'b0;
    end
  end

  // ********************************************************************
  // Receive double buffer
  // ********************************************************************
  // A word that lands as the flag clears goes straight in unless a word is held, then it is held; no word lost
  always @(posedge clk) begin
    if (srst) begin
      data_r    <= `SPIBUF_DATA_RST;
      held_r    <= `SPIBUF_DATA_RST;
      held_v_r  <= 1'b0;
      rc_r      <= 1'b0;
      seen_rc_r <= 1'b0;
    end else begin
      if (st_rd)
        seen_rc_r <= rc_r;
      if (rc_clr) begin
        seen_rc_r <= 1'b0;
        rc_r      <= held_v_r;
        held_v_r  <= 1'b0;
        if (held_v_r)
          data_r <= held_r;
      end
      if (eng_start && held_v_r && !rc_clr)
        held_v_r <= 1'b0;
      if (eng_done) begin
        if (!rc_r || (rc_clr && !held_v_r)) begin
          data_r <= eng_rx;
          rc_r   <= 1'b1;
        end else begin
          held_r   <= eng_rx;
          held_v_r <= 1'b1;
        end
      end
    end
  end

  // ********************************************************************
  // Pin enables and interrupt
  // ********************************************************************
  // Outputs follow master select, so a fault releases the clock and master out pins
  always @(posedge clk) begin
    if (srst) begin
      sck_oe_n  <= 1'b1;
      mosi_oe_n <= 1'b1;
      miso_oe_n <= 1'b1;
      irq       <= 1'b0;
    end else begin
      sck_oe_n  <= ~master_r | fault;
      mosi_oe_n <= ~master_r | fault;
      miso_oe_n <= master_r | ss_n_s;
      irq       <= irq_en_r & (mf_r | rc_r);
    end
  end

  // ********************************************************************
  // Shift engine
  // ********************************************************************
  spibuf_shifter u_shifter (
    .clk      (clk),
    .srst     (srst),
    .master   (master_r),
    .wide     (wide_r),
    .abort    (fault),
    .tx_valid (tx_full_r),
    .tx_word  (tx_r),
    .sck_s    (sck_s),
    .mosi_s   (mosi_s),
    .miso_s   (miso_s),
    .ss_n_s   (ss_n_s),
    .taken_r  (eng_taken),
    .start_r  (eng_start),
    .done_r   (eng_done),
    .rx_r     (eng_rx),
    .sck_r    (eng_sck),
    .dout_r   (eng_dout)
  );

  assign sck_o  = eng_sck;
  assign mosi_o = eng_dout;
  assign miso_o = eng_dout;

endmodule // spibuf_top
`default_nettype wire

// ### core/spibuf_defines.vh
// Constants for the serial status and data buffer block
//
// Function
// - Status register readable any time; writes to it change nothing.
// - Receive-complete flag, status bit 7, sets when data reaches data reg.
// - Transmit-empty flag, status bit 5, is one exactly while tx reg empty.
// - Mode-fault flag, bit 4, sets on select low as master with detect on.
// - Status read seeing mode fault, then control one write, clears it.
// - 8-bit: status read with flag set, then low byte read clears flag.
// - 16-bit: high byte reads never clear; low read after status read does.
// - 16-bit: clearing by low byte read alone discards the high byte.
// - 8-bit: status read with empty set, then low byte write, loads data.
// - Data byte writes while transmit-empty is zero are ignored.
// - 16-bit: high writes keep empty flag; low write after status clears.
// - 16-bit: loading only the low byte leaves high byte undefined.
// - One data address: reads give received data, writes queue transmit.
// - Master starts queued data right after the previous transfer ends.
// - Data reads allowed any time; valid only while receive flag is set.
// - Word received with flag clear goes to data register, flag sets.
// - Word received with flag set is held; data register unchanged.
// - Flag cleared before third transfer starts: held word moves in, flag set.
// - Flag cleared after third transfer starts: held word is dropped.
// - Mode fault clears master select, disables outputs, aborts transfer; here miso drives again as slave while select stays low.
// - Interrupt requested when mode fault sets with interrupt enable set.
`ifndef SPIBUF_DEFINES_VH
`define SPIBUF_DEFINES_VH

// ********************************************************************
// Register indices (byte address is four times the index)
// ********************************************************************
`define SPIBUF_IDX_CTRL1   4'h0
`define SPIBUF_IDX_CTRL2   4'h1
`define SPIBUF_IDX_STATUS  4'h3
`define SPIBUF_IDX_DHI     4'h4
`define SPIBUF_IDX_DLO     4'h5

// ********************************************************************
// Field positions
// ********************************************************************
`define SPIBUF_RC_BIT      7
`define SPIBUF_TE_BIT      5
`define SPIBUF_MF_BIT      4
`define SPIBUF_IRQEN_BIT   7
`define SPIBUF_MASTER_SELECT_BIT    4
`define SPIBUF_FDE_BIT     4
`define SPIBUF_WIDTH_BIT   6

// ********************************************************************
// Reset values and bus answers
// ********************************************************************
`define SPIBUF_DATA_RST    16'h0000
`define SPIBUF_CTRL_RST    8'h00
`define SPIBUF_RESP_OKAY   2'b00
`define SPIBUF_RESP_SLVERR 2'b10

// ********************************************************************
// Timing: master serial clock half period
// ********************************************************************
`define SPIBUF_CLK_NS      4
`define SPIBUF_SCK_HALF_NS 40
`define SPIBUF_HALF_CYC    (`SPIBUF_SCK_HALF_NS / `SPIBUF_CLK_NS)

`endif

// ### core/spibuf_shifter.v
// Serial shift engine for master and slave transfers, mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
`include "spibuf_defines.vh"

module spibuf_shifter (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Mode
  input  wire        master,
  input  wire        wide,
  input  wire        abort,
  // Transmit word offer
  input  wire        tx_valid,
  input  wire [15:0] tx_word,
  // Synchronised pins
  input  wire        sck_s,
  input  wire        mosi_s,
  input  wire        miso_s,
  input  wire        ss_n_s,
  // Events and data
  output reg         taken_r,
  output reg         start_r,
  output reg         done_r,
  output reg  [15:0] rx_r,
  // Pin drive
  output reg         sck_r,
  output reg         dout_r
);

  localparam integer HALF_I  = (`SPIBUF_HALF_CYC) - 1;
  localparam [7:0]   HALF_M1 = HALF_I[7:0];

  reg        busy_r;
  reg        sck_d_r;
  reg [4:0]  cnt_r;
  reg [7:0]  div_r;
  reg [15:0] sh_r;
  wire [4:0] nbits = wide ? 5'h10 : 5'h08;
  wire       msb   = wide ? sh_r[15] : sh_r[7];
  wire       ld_msb = wide ? tx_word[15] : tx_word[7];

  // ********************************************************************
  // Shift sequencer
  // ********************************************************************
  // Data changes on the falling edge and is sampled on the rising edge
  always @(posedge clk) begin
    taken_r <= 1'b0;
    start_r <= 1'b0;
    done_r  <= 1'b0;
    sck_d_r <= sck_s;
    if (srst || abort) begin
      busy_r <= 1'b0;
      sck_r  <= 1'b0;
      cnt_r  <= 5'h00;
      div_r  <= 8'h00;
      sh_r   <= 16'h0000;
      dout_r <= 1'b0;
      rx_r   <= `SPIBUF_DATA_RST;
    end else if (!busy_r) begin
      // Master waits for data, slave waits for select
      if (master ? tx_valid : !ss_n_s) begin
        busy_r  <= 1'b1;
        start_r <= 1'b1;
        taken_r <= tx_valid;
        sh_r    <= tx_valid ? tx_word : 16'h0000;
        dout_r  <= tx_valid ? ld_msb : 1'b0;
        cnt_r   <= 5'h00;
        div_r   <= 8'h00;
        sck_r   <= 1'b0;
      end
    end else if (master) begin
      if (div_r == HALF_M1) begin
        div_r <= 8'h00;
        sck_r <= ~sck_r;
        if (!sck_r) begin
          sh_r  <= {sh_r[14:0], miso_s};
          cnt_r <= cnt_r + 5'h01;
        end else if (cnt_r == nbits) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          rx_r   <= wide ? sh_r : {8'h00, sh_r[7:0]};
        end else begin
          dout_r <= msb;
        end
      end else begin
        div_r <= div_r + 8'h01;
      end
    end else if (ss_n_s) begin
      // Deselect forces the slave idle without a result
      busy_r <= 1'b0;
    end else if (sck_s && !sck_d_r) begin
      sh_r  <= {sh_r[14:0], mosi_s};
      cnt_r <= cnt_r + 5'h01;
      if (cnt_r + 5'h01 == nbits) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
        rx_r   <= wide ? {sh_r[14:0], mosi_s} : {8'h00, sh_r[6:0], mosi_s};
      end
    end else if (!sck_s && sck_d_r) begin
      dout_r <= msb;
    end
  end

endmodule // spibuf_shifter
`default_nettype wire

// ### tb/spibuf_properties.sv
// Port-level checker for the serial status and data buffer block
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// Checker
// ************************************************************
module spibuf_properties (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  // Pins
  input wire logic        sck_oe_n,
  input wire logic        mosi_oe_n,
  input wire logic        miso_oe_n,
  input wire logic        ss_n_i,
  input wire logic        irq
);
  logic [7:0] awq_r;
  logic       fde_r;
  logic       ien_r;
  wire awt = s_axi_awvalid && s_axi_awready;
  wire wrt = s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Shadow of control bits; leads the block by a cycle, bounds allow it
  always @(posedge clk) begin
    if (srst) begin
      awq_r <= 8'h00;
      fde_r <= 1'b0;
      ien_r <= 1'b0;
    end else begin
      if (awt) awq_r <= s_axi_awaddr;
      if (awt && wrt && s_axi_awaddr == 8'h04) fde_r <= s_axi_wdata[4];
      if (awt && wrt && s_axi_awaddr == 8'h00) ien_r <= s_axi_wdata[7];
    end
  end
  sequence s_fault;
    fde_r && !sck_oe_n && !ss_n_i ##1 !ss_n_i;
  endsequence
  a_fault_off: assert property (s_fault |-> ##[1:6] sck_oe_n)
    else $error("master drive kept after mode fault");
  a_oe_pair: assert property (sck_oe_n == mosi_oe_n)
    else $error("clock and data enables disagree");
  a_miso_quiet: assert property (ss_n_i [*4] |-> miso_oe_n)
    else $error("slave output driven while unselected");
  a_irq_gate: assert property (!ien_r [*3] |-> !irq)
    else $error("interrupt raised while disabled");
  a_wstat_ok: assert property ($rose(s_axi_bvalid) && awq_r == 8'h0C
    |-> s_axi_bresp == 2'b00)
    else $error("status write not answered okay");
  a_read_ans: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_stat_rd: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 8'h0C |=> s_axi_rresp == 2'b00)
    else $error("status read refused");
  a_data_rd: assert property (s_axi_arvalid && s_axi_arready &&
    (s_axi_araddr == 8'h10 || s_axi_araddr == 8'h14)
    |=> s_axi_rresp == 2'b00)
    else $error("data read refused");
endmodule // spibuf_properties
`default_nettype wire

// ### tb/spibuf_peer.sv
// Serial peripheral model on the far side: mode 0, MSB first
`timescale 1ns/1ps
`default_nettype none
module spibuf_peer (
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        load,
  input  wire logic [31:0] seed,
  output wire logic        miso,
  output var  logic [31:0] rx,
  output var  logic [7:0]  nbits
);
  logic [31:0] sh;
  assign miso = sh[31];
  // Capture on rising clock, count bits to find frame ends
  always @(posedge sck or posedge load) begin
    if (load) begin
      rx    <= 32'h0;
      nbits <= 8'h00;
    end else begin
      rx    <= {rx[30:0], mosi};
      nbits <= nbits + 8'h01;
    end
  end
  // Rotate so one seed serves several frames
  always @(negedge sck or posedge load) begin
    if (load) sh <= seed;
    else sh <= {sh[30:0], sh[31]};
  end
endmodule // spibuf_peer
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench for the serial status and data buffer block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, srst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic ss = 1, load = 0, msck = 0, mmosi = 0;
  logic [7:0] awa = 0, ara = 0;
  logic [31:0] wd = 0, seed = 0, d;
  logic [1:0] rs;
  wire awr, wrd, bv, arr, rv, irq, sck_o, mosi_o, miso_o, pmiso;
  wire sck_oe_n, mosi_oe_n, miso_oe_n;
  wire [1:0] brs, rrs;
  wire [31:0] rdt, prx;
  wire [7:0] nb;
  int failures = 0, n_compared = 0;
  // Bench acts as link master whenever the block releases the lines
  wire sck_w = sck_oe_n ? msck : sck_o;
  wire mosi_w = mosi_oe_n ? mmosi : mosi_o;
  wire miso_w = miso_oe_n ? pmiso : miso_o;
  spibuf_top spibuf_top_i (.clk(clk), .srst(srst),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_bresp(brs), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .s_axi_rdata(rdt), .s_axi_rresp(rrs), .sck_i(sck_w), .sck_o(sck_o),
    .sck_oe_n(sck_oe_n), .mosi_i(mosi_w), .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_n(miso_oe_n), .ss_n_i(ss), .irq(irq));
  spibuf_peer spibuf_peer_i (.sck(sck_w), .mosi(mosi_w), .load(load),
    .seed(seed), .miso(pmiso), .rx(prx), .nbits(nb));
  always #2 clk = ~clk;
  task end_sim;
    if (failures == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input [31:0] s, input [31:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Bus cycles; both offered together, each released when taken
  task wr(input [7:0] a, input [7:0] v);
    int n;
    @(posedge clk);
    awa <= a; wd <= {24'h0, v}; awv <= 1; wv <= 1; bre <= 1; n = 0;
    do begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
      n++;
    end while (bv !== 1 && n < 99);
    rs = brs; bre <= 0;
    if (n >= 99) failures++;
  endtask
  task rd(input [7:0] a);
    int n;
    @(posedge clk);
    ara <= a; arv <= 1; rre <= 1; n = 0;
    do begin
      @(posedge clk);
      if (arr) arv <= 0;
      n++;
    end while (rv !== 1 && n < 99);
    d = rdt; rs = rrs; rre <= 0;
    if (n >= 99) failures++;
  endtask
  // Poll status until a bit reaches a value, bounded
  task wst(input int b, input logic v);
    int n;
    n = 0;
    do begin rd(8'h0C); n++; end while (d[b] !== v && n < 300);
    chk(d[b], v);
  endtask
  task pl(input [31:0] s);
    @(posedge clk); seed <= s; load <= 1;
    @(posedge clk); load <= 0;
  endtask
  // Wait for the peer to count k link bits, then for sync and flags
  task pw(input [7:0] k);
    int n;
    n = 0;
    while (nb < k && n < 4000) begin @(posedge clk); n++; end
    if (n >= 4000) failures++;
    repeat (16) @(posedge clk);
  endtask
  task send(input [7:0] v);
    wst(5, 1'b1);
    wr(8'h14, v);
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_regs;
    rd(8'h0C); chk(d & 32'hB0, 32'h20);
    wr(8'h0C, 8'hFF); chk(rs, 2'b00);
    rd(8'h0C); chk(d & 32'hB0, 32'h20);
    rd(8'h14); chk(d[7:0], 8'h00);
    rd(8'h08); chk(rs, 2'b10);
  endtask
  task t_back8;
    pl(32'hA5C35A96); wr(8'h04, 8'h00); wr(8'h00, 8'h10);
    send(8'h3C); send(8'h5A); wr(8'h14, 8'hFF);
    wst(7, 1'b1);
    pw(16); chk(prx[15:0], 16'h3C5A);
    rd(8'h0C); rd(8'h14); chk(d[7:0], 8'hA5);
    rd(8'h0C); chk(d[7], 1'b1);
    rd(8'h14); chk(d[7:0], 8'hC3);
  endtask
  task t_late3;
    pl(32'h5A96A5C3); send(8'h11); send(8'h22); send(8'h33); pw(17);
    rd(8'h0C); rd(8'h14); chk(d[7:0], 8'h5A);
    rd(8'h0C); chk(d[7], 1'b0);
    wst(7, 1'b1); rd(8'h14); chk(d[7:0], 8'hA5);
  endtask
  task t_wide;
    pl(32'hBEEF0000); wr(8'h04, 8'h40); wst(5, 1'b1); wr(8'h10, 8'h12);
    rd(8'h0C); chk(d[5], 1'b1);
    wr(8'h10, 8'h12); wr(8'h14, 8'h34); pw(16);
    chk(prx[15:0], 16'h1234);
    rd(8'h0C); rd(8'h10); rd(8'h10); chk(d[7:0], 8'hBE);
    rd(8'h0C); chk(d[7], 1'b1);
    rd(8'h14); chk(d[7:0], 8'hEF);
    rd(8'h0C); chk(d[7], 1'b0);
  endtask
  task t_fault;
    wr(8'h04, 8'h10); wr(8'h00, 8'h90);
    ss <= 0; repeat (8) @(posedge clk);
    ss <= 1; repeat (8) @(posedge clk);
    rd(8'h00); chk(d[4], 1'b0);
    wr(8'h00, 8'h80); rd(8'h0C); chk(d[4], 1'b1);
    chk(irq, 1'b1);
    wr(8'h00, 8'h80); rd(8'h0C); chk(d[4], 1'b0);
    chk(irq, 1'b0);
  endtask
  // Bench clocks one byte in as link master, 80 ns period
  task t_slave;
    int i;
    logic [7:0] v;
    v = 8'hC6;
    ss <= 0; repeat (4) @(posedge clk);
    for (i = 7; i >= 0; i--) begin
      mmosi <= v[i]; repeat (10) @(posedge clk);
      msck <= 1; repeat (10) @(posedge clk);
      msck <= 0;
    end
    repeat (8) @(posedge clk); ss <= 1;
    wst(7, 1'b1);
    rd(8'h14); chk(d[7:0], 8'hC6);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    srst <= 0;
    t_regs; t_back8; t_late3; t_wide; t_fault; t_slave;
    end_sim;
  end
  // Whole run is a few thousand cycles; this bound is generous
  initial begin
    #100000;
    failures++;
    end_sim;
  end
endmodule // tb
bind spibuf_top spibuf_properties spibuf_properties_i (.*);
`default_nettype wire
